// file: qrw_flash_cmd.sv
// Purpose: Serial flash command handling for quad I/O reads (SDR and DTR)
//          with continuous-read mode, burst wrap setup and page program.
// Assumes: Serial clock, chip select and data lines oversampled by mclk_in.
// Notes:   Array data and page buffer live outside this block.
// Functional notes
// - Quad read: four lines, four dummy clocks
// - Quad read needs quad enable bit
// - Mode byte bits 5:4 steer next read
// - Mode bits 5:4 = 10 skip next opcode
// - Other mode value needs full opcode again
// - Wrapped read stays in aligned section
// - Wrap command: opcode, 24 dummy, 8 bits
// - Disable bit zero enables 8-64 byte wrap
// - Wrap applies later; disable resets to one
// - Four-line mode: mode byte counts as dummy
// - Four-line mode quad reads never wrap
// - Four-line dummy 2/4/6/8, default 2
// - Wrap length kept, read parameters change it
// - Program ignored unless write enable latched
// - Program addresses wrap inside the page
// - Program only if select rises byte-aligned
// - Busy while programming, status still readable
// - Protected pages are never programmed
`timescale 1ns/1ps
module qrw_flash_cmd
   import qrw_pkg::*;
#(
   parameter int PROG_TIME_NS = 700000
) (
   // Clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Serial link pins
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic [3:0] io_in,
   output logic [3:0] io_data_out,
   output logic [3:0] io_oe_out,
   // Configuration and protection
   input wire logic quad_enable_bit_in,
   input wire logic four_line_command_mode_in,
   input wire logic page_protected_in,
   // Array access
   output logic [23:0] mem_addr_out,
   input wire logic [7:0] mem_rdata_in,
   output logic load_we_out,
   output logic [23:0] load_addr_out,
   output logic [7:0] load_data_out,
   output logic program_start_out,
   // Status
   output logic busy_out,
   output logic write_enable_latch_out,
   output logic wrap_disable_bit_out,
   output logic continuous_read_out
);
   localparam int PROG_CYCLES_I =
      (PROG_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PROG_TIME_NS / CLK_PERIOD_NS;
   localparam logic [19:0] PROG_LAST = 20'(PROG_CYCLES_I - 1);

   logic [5:0] pins;
   logic sclk_d, cs_d, next_sclk_d, next_cs_d;
   logic rise, fall, cs_fall, cs_rise;

   qrw_sync #(.WIDTH(SYNC_WIDTH), .RST_VAL(SYNC_RST)) u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .d_in({sclk_in, cs_n_in, io_in}),
      .q_out(pins)
   );

   qrw_state_t state, next_state;
   logic [23:0] in_sh, next_in_sh, addr, next_addr;
   logic [5:0] bcnt, next_bcnt;
   logic four_line_command_mode, next_qpi, dtr, next_dtr, nib, next_nib;
   logic cont_read, next_cont_read;
   logic wrap_dis, next_wrap_dis;
   logic [1:0] wrap_len, next_wrap_len, dummy_code, next_dummy_code;
   logic [3:0] dum_left, next_dum_left;
   logic write_enable_latch, next_wel, busy, next_busy;
   logic [19:0] busy_cnt, next_busy_cnt;
   logic [7:0] pp_off, next_pp_off;
   logic pp_any, next_pp_any;
   logic [3:0] next_io_data, next_io_oe;
   logic next_load_we, next_commit;
   logic [23:0] next_load_addr;
   logic [7:0] next_load_data;

   // Helper terms
   logic wide, samp, drive_ev, cmd_done, wrap_on;
   logic [23:0] shifted;
   logic [5:0] nbits;
   logic [7:0] cmd_byte, stat;
   logic [3:0] dum_total;

   function automatic logic [23:0] step_addr(input logic [23:0] a,
      input logic wrap, input logic [1:0] len);
      logic [7:0] m;
      m = (WRAP_MASK_BASE << len) - 8'h01;
      if (wrap) begin
         return {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'h01) & m)};
      end
      return a + 24'h000001;
   endfunction

   always_comb begin
      rise = pins[5] & ~sclk_d;
      fall = ~pins[5] & sclk_d;
      cs_fall = cs_d & ~pins[4];
      cs_rise = ~cs_d & pins[4];
      wide = four_line_command_mode | (state == ST_ADDR) | (state == ST_MODE);
      samp = rise | (dtr & fall & (bcnt != 6'h00) &
                     ((state == ST_ADDR) | (state == ST_MODE)));
      drive_ev = fall | (dtr & rise & (io_oe_out != 4'h0));
      shifted = wide ? {in_sh[19:0], pins[3:0]} : {in_sh[22:0], pins[0]};
      nbits = bcnt + (wide ? QUAD_STEP : SINGLE_STEP);
      cmd_byte = shifted[7:0];
      cmd_done = (state == ST_CMD) & samp & (nbits == CMD_BITS);
      wrap_on = ~wrap_dis & ~four_line_command_mode;
      stat = {6'h00, write_enable_latch, busy};
      if (four_line_command_mode) begin
         dum_total = QPI_DUMMY_BASE + {1'b0, dummy_code, 1'b0} -
                     (dtr ? DTR_MODE_CLKS : SDR_MODE_CLKS);
      end else begin
         dum_total = SPI_DUMMY_CLKS;
      end
      if (dtr && dum_total == 4'h0) begin
         dum_total = 4'h1;
      end
   end

   always_comb begin
      next_sclk_d = pins[5];
      next_cs_d = pins[4];
      next_state = state;
      next_in_sh = in_sh;
      next_addr = addr;
      next_bcnt = bcnt;
      next_qpi = four_line_command_mode;
      next_dtr = dtr;
      next_nib = nib;
      next_cont_read = cont_read;
      next_wrap_dis = wrap_dis;
      next_wrap_len = wrap_len;
      next_dummy_code = dummy_code;
      next_dum_left = dum_left;
      next_wel = write_enable_latch;
      next_busy = busy;
      next_busy_cnt = busy_cnt;
      next_pp_off = pp_off;
      next_pp_any = pp_any;
      next_io_data = io_data_out;
      next_io_oe = io_oe_out;
      next_load_we = 1'b0;
      next_commit = 1'b0;
      next_load_addr = load_addr_out;
      next_load_data = load_data_out;
      if (busy) begin
         next_busy_cnt = busy_cnt + 20'h00001;
         if (busy_cnt == PROG_LAST) begin
            next_busy = 1'b0;
            next_busy_cnt = 20'h00000;
            next_wel = 1'b0;
         end
      end
      if (cs_rise) begin
         next_state = ST_IDLE;
         next_io_oe = 4'h0;
         if (state == ST_WREN) begin
            next_wel = 1'b1;
         end else if (state == ST_PPADDR || state == ST_PPDATA) begin
            if (state == ST_PPDATA && pp_any && bcnt == 6'h00 &&
                !page_protected_in) begin
               next_busy = 1'b1;
               next_busy_cnt = 20'h00000;
               next_commit = 1'b1;
            end else begin
               next_wel = 1'b0;
            end
         end
      end else if (cs_fall) begin
         next_qpi = four_line_command_mode_in;
         next_bcnt = 6'h00;
         next_nib = 1'b0;
         next_in_sh = 24'h000000;
         next_state = (cont_read && !busy) ? ST_ADDR : ST_CMD;
      end else if (!pins[4]) begin
         case (state)
            ST_CMD: begin
               if (samp) begin
                  next_in_sh = shifted;
                  next_bcnt = nbits;
               end
               if (cmd_done) begin
                  next_bcnt = 6'h00;
                  next_state = ST_IGN;
                  if (cmd_byte == OP_STATUS) begin
                     next_state = ST_STAT;
                  end else if (busy) begin
                     next_state = ST_IGN;
                  end else if (cmd_byte == OP_WREN) begin
                     next_state = ST_WREN;
                  end else if (cmd_byte == OP_QREAD ||
                               cmd_byte == OP_QREAD_DTR) begin
                     if (quad_enable_bit_in) begin
                        next_state = ST_ADDR;
                        next_dtr = (cmd_byte == OP_QREAD_DTR);
                     end
                  end else if (cmd_byte == OP_SET_WRAP && !four_line_command_mode) begin
                     next_state = ST_WRAP;
                  end else if (cmd_byte == OP_READ_PARAM) begin
                     next_state = ST_RPAR;
                  end else if (cmd_byte == OP_PROG) begin
                     next_state = write_enable_latch ? ST_PPADDR : ST_IGN;
                  end
               end
            end
            ST_ADDR: begin
               if (samp) begin
                  next_in_sh = shifted;
                  next_bcnt = nbits;
                  if (nbits == ADDR_BITS) begin
                     next_addr = shifted;
                     next_bcnt = 6'h00;
                     next_state = ST_MODE;
                  end
               end
            end
            ST_MODE: begin
               if (samp) begin
                  next_in_sh = shifted;
                  next_bcnt = nbits;
                  if (nbits == MODE_BITS) begin
                     next_cont_read =
                        (shifted[MODE_CONT_HI:MODE_CONT_LO] == CONT_ENTER);
                     next_bcnt = 6'h00;
                     next_dum_left = dum_total;
                     next_state = (dum_total == 4'h0) ? ST_DATA : ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               if (rise) begin
                  next_dum_left = dum_left - 4'h1;
                  if (dum_left == 4'h1) begin
                     next_state = ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (drive_ev) begin
                  next_io_oe = 4'hF;
                  next_io_data = nib ? mem_rdata_in[3:0] : mem_rdata_in[7:4];
                  next_nib = ~nib;
                  if (nib) begin
                     next_addr = step_addr(addr, wrap_on, wrap_len);
                  end
               end
            end
            ST_STAT: begin
               if (fall) begin
                  next_bcnt = bcnt + 6'h01;
                  if (four_line_command_mode) begin
                     next_io_oe = 4'hF;
                     next_io_data = bcnt[0] ? stat[3:0] : stat[7:4];
                  end else begin
                     next_io_oe = 4'h2;
                     next_io_data = {2'h0, stat[3'h7 - bcnt[2:0]], 1'b0};
                  end
               end
            end
            ST_WRAP: begin
               // dummy bits then wrap bits; decode
               if (samp) begin
                  next_in_sh = shifted;
                  next_bcnt = nbits;
                  if (nbits == WRAP_FRAME_BITS) begin
                     next_wrap_dis = shifted[WRAP_DIS_POS];
                     next_wrap_len = shifted[WRAP_LEN_HI:WRAP_LEN_LO];
                     next_state = ST_IGN;
                  end
               end
            end
            ST_RPAR: begin
               if (samp) begin
                  next_in_sh = shifted;
                  next_bcnt = nbits;
                  if (nbits == BYTE_BITS) begin
                     next_dummy_code = shifted[RP_DUMMY_HI:RP_DUMMY_LO];
                     next_wrap_len = shifted[RP_WRAP_HI:RP_WRAP_LO];
                     next_state = ST_IGN;
                  end
               end
            end
            ST_PPADDR: begin
               if (samp) begin
                  next_in_sh = shifted;
                  next_bcnt = nbits;
                  if (nbits == ADDR_BITS) begin
                     next_addr = shifted;
                     next_bcnt = 6'h00;
                     next_pp_off = 8'h00;
                     next_pp_any = 1'b0;
                     next_state = ST_PPDATA;
                  end
               end
            end
            ST_PPDATA: begin
               if (samp) begin
                  next_in_sh = shifted;
                  next_bcnt = nbits;
                  if (nbits == BYTE_BITS) begin
                     next_bcnt = 6'h00;
                     next_load_we = 1'b1;
                     next_load_data = shifted[7:0];
                     next_load_addr = {addr[23:8], addr[7:0] + pp_off};
                     next_pp_off = pp_off + 8'h01;
                     next_pp_any = 1'b1;
                  end
               end
            end
            default: begin
               next_state = state;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
         state <= ST_IDLE;
         in_sh <= 24'h000000;
         addr <= 24'h000000;
         bcnt <= 6'h00;
         four_line_command_mode <= 1'b0;
         dtr <= 1'b0;
         nib <= 1'b0;
         cont_read <= 1'b0;
         wrap_dis <= WRAP_DIS_RST;
         wrap_len <= WRAP_LEN_RST;
         dummy_code <= DUMMY_CODE_RST;
         dum_left <= 4'h0;
         write_enable_latch <= 1'b0;
         busy <= 1'b0;
         busy_cnt <= 20'h00000;
         pp_off <= 8'h00;
         pp_any <= 1'b0;
         io_data_out <= 4'h0;
         io_oe_out <= 4'h0;
         load_we_out <= 1'b0;
         program_start_out <= 1'b0;
         load_addr_out <= 24'h000000;
         load_data_out <= 8'h00;
      end else if (ce_in) begin
         sclk_d <= next_sclk_d;
         cs_d <= next_cs_d;
         state <= next_state;
         in_sh <= next_in_sh;
         addr <= next_addr;
         bcnt <= next_bcnt;
         four_line_command_mode <= next_qpi;
         dtr <= next_dtr;
         nib <= next_nib;
         cont_read <= next_cont_read;
         wrap_dis <= next_wrap_dis;
         wrap_len <= next_wrap_len;
         dummy_code <= next_dummy_code;
         dum_left <= next_dum_left;
         write_enable_latch <= next_wel;
         busy <= next_busy;
         busy_cnt <= next_busy_cnt;
         pp_off <= next_pp_off;
         pp_any <= next_pp_any;
         io_data_out <= next_io_data;
         io_oe_out <= next_io_oe;
         load_we_out <= next_load_we;
         program_start_out <= next_commit;
         load_addr_out <= next_load_addr;
         load_data_out <= next_load_data;
      end
   end

   assign mem_addr_out = addr;
   assign busy_out = busy;
   assign write_enable_latch_out = write_enable_latch;
   assign wrap_disable_bit_out = wrap_dis;
   assign continuous_read_out = cont_read;

   default clocking cb @(posedge mclk_in iff ce_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_cmd_start;
      cs_fall && !(cont_read && !busy);
   endsequence
   sequence s_pp_end;
      cs_rise && state == ST_PPDATA;
   endsequence

   quad_gate_a: assert property (cmd_done && cmd_byte == OP_QREAD
      && !quad_enable_bit_in |=> state == ST_IGN)
      else $error("quad read taken without quad enable");
   cont_skip_a: assert property (cs_fall && cont_read && !busy
      |=> state == ST_ADDR)
      else $error("continuous read did not skip opcode");
   opcode_need_a: assert property (s_cmd_start |=> state == ST_CMD)
      else $error("opcode phase missing");
   wrap_reset_a: assert property ($rose(rst_n_in) |-> wrap_dis)
      else $error("wrap disable not set after reset");
   dummy_reset_a: assert property ($rose(rst_n_in)
      |-> dummy_code == DUMMY_CODE_RST)
      else $error("dummy code not default after reset");
   pp_wel_a: assert property (cmd_done && cmd_byte == OP_PROG
      && !busy && !write_enable_latch |=> state == ST_IGN)
      else $error("program accepted without write enable");
   pp_align_a: assert property (s_pp_end ##0 bcnt != 6'h00
      |=> !program_start_out && !write_enable_latch)
      else $error("misaligned program not discarded");
   busy_done_a: assert property ($fell(busy) |-> !write_enable_latch)
      else $error("write enable left set after program");
   protect_a: assert property (program_start_out
      |-> $past(!page_protected_in))
      else $error("protected page programmed");
   wrap_page_a: assert property (state == ST_DATA && wrap_on
      && $changed(addr) |-> addr[23:8] == $past(addr[23:8]))
      else $error("wrapped read left its page");
endmodule

// file: qrw_pkg.sv
// Purpose: Shared constants and types for the quad read / wrap / program
//          command block.
// Assumes: One system clock at 10 MHz oversampling the serial link.
// Notes:   Opcodes, field positions, reset values and cycle figures.
package qrw_pkg;
   // System clock
   localparam int CLK_PERIOD_NS = 100;

   // Opcodes
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_SET_WRAP = 8'h77;
   localparam logic [7:0] OP_READ_PARAM = 8'hC0;
   localparam logic [7:0] OP_QREAD = 8'hEB;
   localparam logic [7:0] OP_QREAD_DTR = 8'hED;

   // Phase lengths in bits
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h18;
   localparam logic [5:0] MODE_BITS = 6'h08;
   localparam logic [5:0] BYTE_BITS = 6'h08;
   localparam logic [5:0] WRAP_FRAME_BITS = 6'h20;
   localparam logic [5:0] QUAD_STEP = 6'h04;
   localparam logic [5:0] SINGLE_STEP = 6'h01;

   // Dummy clock counts
   localparam logic [3:0] SPI_DUMMY_CLKS = 4'h4;
   localparam logic [3:0] QPI_DUMMY_BASE = 4'h2;
   localparam logic [3:0] SDR_MODE_CLKS = 4'h2;
   localparam logic [3:0] DTR_MODE_CLKS = 4'h1;

   // Field positions
   localparam int MODE_CONT_HI = 5;
   localparam int MODE_CONT_LO = 4;
   localparam logic [1:0] CONT_ENTER = 2'h2;
   localparam int WRAP_DIS_POS = 4;
   localparam int WRAP_LEN_HI = 6;
   localparam int WRAP_LEN_LO = 5;
   localparam int RP_DUMMY_HI = 5;
   localparam int RP_DUMMY_LO = 4;
   localparam int RP_WRAP_HI = 1;
   localparam int RP_WRAP_LO = 0;
   localparam logic [7:0] WRAP_MASK_BASE = 8'h08;

   // Reset values
   localparam logic WRAP_DIS_RST = 1'h1;
   localparam logic [1:0] WRAP_LEN_RST = 2'h0;
   localparam logic [1:0] DUMMY_CODE_RST = 2'h0;

   // Synchroniser lanes: {sclk, cs_n, io[3:0]}
   localparam int SYNC_WIDTH = 6;
   localparam logic [5:0] SYNC_RST = 6'h10;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_STAT,
      ST_WREN, ST_WRAP, ST_RPAR, ST_PPADDR, ST_PPDATA, ST_IGN
   } qrw_state_t;
endpackage

// file: qrw_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain.
// Assumes: Inputs are slow relative to mclk_in.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module qrw_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and control
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Data
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_q;

   always_comb begin
      next_stage1 = stage1;
      next_q = q_out;
      if (!rst_n_in) begin
         next_stage1 = RST_VAL;
         next_q = RST_VAL;
      end else if (ce_in) begin
         next_stage1 = d_in;
         next_q = stage1;
      end
   end

   always_ff @(posedge mclk_in) begin
      stage1 <= next_stage1;
      q_out <= next_q;
   end
endmodule

// file: qrw_host.sv
// Purpose: Host controller model driving the serial flash link.
// Assumes: Mode 0, sclk of 8 mclk periods (10 in ddr), moves 1 ns after mclk rise.
// Notes:   Released lines show the inverse of the last driven value.
`timescale 1ns/1ps
module qrw_host (
   // Clock
   input wire logic mclk_in,
   // Device drive of the shared lines
   input wire logic [3:0] dev_data_in,
   input wire logic [3:0] dev_oe_in,
   // Link pins
   output logic sclk_out,
   output logic cs_n_out,
   output logic [3:0] io_out
);
   logic [3:0] drv = 4'h0;
   logic hen = 1'b0;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
   end
   assign io_out = (dev_oe_in & dev_data_in) |
                   (~dev_oe_in & (hen ? drv : ~drv));
   task automatic half(input logic lvl);
      repeat (4) @(posedge mclk_in);
      #1 sclk_out = lvl;
   endtask
   task automatic clk(input logic [3:0] v, input logic en,
                      output logic [3:0] got);
      if (en)
         drv = v;
      hen = en;
      half(1'b1);
      got = io_out;
      half(1'b0);
   endtask
   // one nibble per edge, held across each edge
   task automatic ddr(input logic [3:0] a, input logic [3:0] b,
                      input logic en, output logic [3:0] ga,
                      output logic [3:0] gb);
      if (en)
         drv = a;
      hen = en;
      half(1'b1);
      ga = io_out;
      repeat (2) @(posedge mclk_in);
      #1;
      if (en)
         drv = b;
      half(1'b0);
      gb = io_out;
   endtask
   task automatic send(input logic [31:0] v, input int n, input logic quad);
      logic [3:0] g;
      for (int i = n - 1; i >= 0; i--) begin
         if (quad)
            clk(v[4*i +: 4], 1'b1, g);
         else
            clk({3'h0, v[i]}, 1'b1, g);
      end
   endtask
   task automatic sel();
      @(posedge mclk_in);
      #1 cs_n_out = 1'b0;
   endtask
   task automatic desel();
      repeat (4) @(posedge mclk_in);
      #1 cs_n_out = 1'b1;
      hen = 1'b0;
      repeat (8) @(posedge mclk_in);
      #1;
   endtask
endmodule

// file: qrw_flash_cmd_test.sv
// Purpose: Self-checking bench for the flash command block.
// Assumes: Array byte is its address low byte xor A5.
// Notes:   Program time cut to 40000 ns, still long enough for status reads to see busy.
`timescale 1ns/1ps
module qrw_flash_cmd_test
   import qrw_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic qe = 1'b0;
   logic prot = 1'b0;
   logic four_line_command_mode = 1'b0;
   int nd = 4;
   logic sclk, cs_n, load_we, pstart, busy, write_enable_latch, wdis, cont, seen_oe;
   logic [3:0] io, io_data, io_oe;
   logic [23:0] mem_addr, load_addr;
   logic [7:0] load_data, st;
   logic [7:0] rb [4];
   logic [7:0] la [$];
   logic [7:0] ld [$];
   int n_errors = 0;
   int comparisons = 0;
   int starts = 0;
   always #50 mclk = ~mclk;
   qrw_flash_cmd #(.PROG_TIME_NS(40000)) u_qrw_flash_cmd (
      .mclk_in(mclk), .rst_n_in(rst_n), .ce_in(1'b1),
      .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io),
      .io_data_out(io_data), .io_oe_out(io_oe),
      .quad_enable_bit_in(qe), .four_line_command_mode_in(four_line_command_mode),
      .page_protected_in(prot), .mem_addr_out(mem_addr),
      .mem_rdata_in(mem_addr[7:0] ^ 8'hA5), .load_we_out(load_we),
      .load_addr_out(load_addr), .load_data_out(load_data),
      .program_start_out(pstart), .busy_out(busy),
      .write_enable_latch_out(write_enable_latch), .wrap_disable_bit_out(wdis),
      .continuous_read_out(cont));
   qrw_host u_qrw_host (
      .mclk_in(mclk), .dev_data_in(io_data), .dev_oe_in(io_oe),
      .sclk_out(sclk), .cs_n_out(cs_n), .io_out(io));
   always @(posedge mclk) begin
      if (io_oe !== 4'h0)
         seen_oe <= 1'b1;
      if (load_we === 1'b1) begin
         la.push_back(load_addr[7:0]);
         ld.push_back(load_data);
      end
      if (pstart === 1'b1)
         starts <= starts + 1;
   end
   task automatic report_and_stop();
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic frame(input logic [7:0] op);
      u_qrw_host.sel();
      u_qrw_host.send({24'h0, op}, 8, 1'b0);
      u_qrw_host.desel();
   endtask
   // Opcode 00 stands for a frame that starts at the address
   task automatic qread(input logic [7:0] op, input logic [23:0] a,
                        input logic [7:0] m, input int nb);
      logic [3:0] hi, lo;
      u_qrw_host.sel();
      if (op !== 8'h00)
         u_qrw_host.send({24'h0, op}, four_line_command_mode ? 2 : 8, four_line_command_mode);
      u_qrw_host.send({8'h0, a}, 6, 1'b1);
      u_qrw_host.send({24'h0, m}, 2, 1'b1);
      // four dummy clocks; fewer in four-line mode
      repeat (nd) u_qrw_host.clk(4'h0, 1'b0, hi);
      for (int i = 0; i < nb; i++) begin
         u_qrw_host.clk(4'h0, 1'b0, hi);
         u_qrw_host.clk(4'h0, 1'b0, lo);
         rb[i] = {hi, lo};
      end
      u_qrw_host.desel();
   endtask
   task automatic set_wrap(input logic [7:0] w);
      u_qrw_host.sel();
      u_qrw_host.send({24'h0, OP_SET_WRAP}, 8, 1'b0);
      u_qrw_host.send({24'h0, w}, 32, 1'b0);
      u_qrw_host.desel();
   endtask
   task automatic prog(input logic [23:0] a, input int extra);
      u_qrw_host.sel();
      u_qrw_host.send({24'h0, OP_PROG}, 8, 1'b0);
      u_qrw_host.send({8'h0, a}, 24, 1'b0);
      u_qrw_host.send(32'h00C3A512, 24, 1'b0);
      u_qrw_host.send(32'h0, extra, 1'b0);
      u_qrw_host.desel();
   endtask
   task automatic status();
      logic [3:0] g;
      u_qrw_host.sel();
      u_qrw_host.send({24'h0, OP_STATUS}, 8, 1'b0);
      for (int i = 7; i >= 0; i--) begin
         u_qrw_host.clk(4'h0, 1'b0, g);
         st[i] = g[1];
      end
      u_qrw_host.desel();
   endtask
   initial begin
      logic [7:0] ea;
      logic [3:0] hi, lo;
      repeat (16) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      check("busy", busy, 1'b0);
      check("wel", write_enable_latch, 1'b0);
      check("wrap disable", wdis, 1'b1);
      check("continuous", cont, 1'b0);
      seen_oe = 1'b0;
      qread(OP_QREAD, 24'h000040, 8'h00, 1);
      check("drive without qe", seen_oe, 1'b0);
      qe = 1'b1;
      for (int l = 0; l < 4; l++) begin
         ea = 8'h3F + (8'h08 << l);
         set_wrap({1'b1, l[1:0], 1'b0, 4'hF});
         check("wrap disable", wdis, 1'b0);
         qread(OP_QREAD, {16'h0, ea}, 8'h00, 2);
         check("wrap first", rb[0], ea ^ 8'hA5);
         check("wrap second", rb[1], 8'h40 ^ 8'hA5);
      end
      set_wrap(8'h10);
      check("wrap disable", wdis, 1'b1);
      qread(OP_QREAD, 24'h000047, 8'h00, 2);
      check("no wrap", rb[1], 8'h48 ^ 8'hA5);
      qread(OP_QREAD, 24'h000120, 8'h2F, 1);
      check("read", rb[0], 8'h20 ^ 8'hA5);
      check("continuous", cont, 1'b1);
      qread(8'h00, 24'h000130, 8'hFF, 1);
      check("no opcode read", rb[0], 8'h30 ^ 8'hA5);
      check("continuous", cont, 1'b0);
      qread(OP_QREAD, 24'h000140, 8'h00, 1);
      check("opcode read", rb[0], 8'h40 ^ 8'hA5);
      u_qrw_host.sel();
      u_qrw_host.send({24'h0, OP_QREAD_DTR}, 8, 1'b0);
      u_qrw_host.ddr(4'h0, 4'h0, 1'b1, hi, lo);
      u_qrw_host.ddr(4'h0, 4'h1, 1'b1, hi, lo);
      u_qrw_host.ddr(4'h5, 4'h0, 1'b1, hi, lo);
      u_qrw_host.ddr(4'h0, 4'h0, 1'b1, hi, lo);
      repeat (4) u_qrw_host.clk(4'h0, 1'b0, hi);
      u_qrw_host.ddr(4'h0, 4'h0, 1'b0, hi, lo);
      check("dtr first", {hi, lo}, 8'h50 ^ 8'hA5);
      u_qrw_host.ddr(4'h0, 4'h0, 1'b0, hi, lo);
      check("dtr second", {hi, lo}, 8'h51 ^ 8'hA5);
      u_qrw_host.desel();
      prog(24'h0000FE, 0);
      check("starts", starts, 0);
      frame(OP_WREN);
      check("wel", write_enable_latch, 1'b1);
      prog(24'h0000FE, 3);
      check("starts", starts, 0);
      check("wel", write_enable_latch, 1'b0);
      frame(OP_WREN);
      prot = 1'b1;
      prog(24'h0000FD, 0);
      check("starts", starts, 0);
      check("wel", write_enable_latch, 1'b0);
      prot = 1'b0;
      frame(OP_WREN);
      la.delete();
      ld.delete();
      prog(24'h0000FE, 0);
      check("starts", starts, 1);
      check("busy", busy, 1'b1);
      check("loads", la.size(), 3);
      check("load first", la[0], 8'hFE);
      check("load wrapped", la[2], 8'h00);
      check("load data first", ld[0], 8'hC3);
      check("load data last", ld[2], 8'h12);
      status();
      check("status", st, 8'h03);
      for (int k = 0; k < 1000 && busy !== 1'b0; k++) begin
         @(posedge mclk);
         #1;
      end
      check("busy", busy, 1'b0);
      check("wel", write_enable_latch, 1'b0);
      set_wrap(8'h80);
      check("wrap disable", wdis, 1'b0);
      four_line_command_mode = 1'b1;
      u_qrw_host.sel();
      u_qrw_host.send({24'h0, OP_READ_PARAM}, 2, 1'b1);
      u_qrw_host.send(32'h00000013, 2, 1'b1);
      u_qrw_host.desel();
      nd = 2;
      qread(OP_QREAD, 24'h00007F, 8'h00, 2);
      check("four-line first", rb[0], 8'h7F ^ 8'hA5);
      check("four-line no wrap", rb[1], 8'h80 ^ 8'hA5);
      four_line_command_mode = 1'b0;
      nd = 4;
      qread(OP_QREAD, 24'h00007F, 8'h00, 2);
      check("kept wrap length", rb[1], 8'h40 ^ 8'hA5);
      report_and_stop();
   end
endmodule
